// >>> verilog/ats_pkg.sv
// Package of constants and types shared by the atomic transaction slave.
// Operation
// - Supporting atomics means every operation, size, endianness.
// - Store combines value, writes memory, response only.
// - Swap writes value, returns previous contents.
// - Compare writes swap value only on match.
// - Compare read data is half outbound size.
// - Returned data is memory before the operation.
// - ADD stores memory plus sent data.
// - CLR clears, SET sets, EOR toggles bits.
// - Signed and unsigned maximum and minimum.
// - Length and size give outbound byte count.
// - Compare at addressed bytes, swap in rest.
// - Single-beat WRAP atomic requests are accepted.
// - Request ID echoed on response and read data.
// - Low operation bits select ADD through UMIN.
// - Bit three selects big-endian for arithmetic.
// - One write response after data and result.
package ats_pkg;
  // Operation field encodings.
  localparam logic [1:0] ATOP_KIND_NONE = 2'h0;
  localparam logic [1:0] ATOP_KIND_STORE = 2'h1;
  localparam logic [1:0] ATOP_KIND_LOAD = 2'h2;
  localparam logic [1:0] ATOP_KIND_OTHER = 2'h3;
  localparam logic [5:0] ATOP_SWAP = 6'h30;
  localparam logic [5:0] ATOP_CMP = 6'h31;
  localparam int ATOP_BIG_BIT = 3;
  // Arithmetic and bitwise operators.
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_CLR = 3'h1;
  localparam logic [2:0] OP_EOR = 3'h2;
  localparam logic [2:0] OP_SET = 3'h3;
  localparam logic [2:0] OP_SMAX = 3'h4;
  localparam logic [2:0] OP_SMIN = 3'h5;
  localparam logic [2:0] OP_UMAX = 3'h6;
  localparam logic [2:0] OP_UMIN = 3'h7;
  // Burst types and responses.
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Size limits in bytes.
  localparam int MAX_CONT_BYTES = 32;
  localparam int MAX_OPND_BYTES = 16;
  localparam int MAX_ARITH_BYTES = 8;
  // Default widths and depth.
  localparam int DEF_DATA_W = 64;
  localparam int DEF_ADDR_W = 32;
  localparam int DEF_ID_W = 4;
  localparam int DEF_MEM_BYTES = 1024;
  localparam bit DEF_ATOMIC_SUPPORT = 1'b1;
  // Reset value of all control state.
  localparam logic RESET_VALUE = 1'b0;

  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_EXEC, ST_RESP} ats_state_t;
endpackage

// >>> verilog/ats_alu.sv
// Arithmetic and bitwise operator unit for store and load atomics.
`timescale 1ns/1ps
module ats_alu (
  input wire logic [63:0] old_i,  // Memory bytes in address order.
  input wire logic [63:0] arg_i,  // Sent bytes in address order.
  input wire logic [2:0] op_i,    // Operator select.
  input wire logic [4:0] size_i,  // Operand size in bytes, 1 to 8.
  input wire logic big_i,         // High for big-endian operands.
  output logic [63:0] res_o       // Result bytes in address order.
);
  // Reorders bytes into value order; self-inverse, so it also maps back.
  function automatic logic [63:0] ats_order(input logic [63:0] v, input int sz, input logic big);
    logic [63:0] o;
    o = '0;
    for (int k = 0; k < 8; k++) begin
      if (k < sz) begin
        o[k*8 +: 8] = big ? v[(sz-1-k)*8 +: 8] : v[k*8 +: 8];
      end
    end
    return o;
  endfunction

  // Values are left-justified so that one 64-bit adder and comparator serve every size.
  always_comb begin
    int sz;
    int sh;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] r;
    r = '0;
    sz = (size_i == 5'h0 || size_i > 5'h8) ? 8 : int'(size_i);
    sh = 8 * (8 - sz);
    a = ats_order(old_i, sz, big_i) << sh;
    b = ats_order(arg_i, sz, big_i) << sh;
    case (op_i)
      ats_pkg::OP_ADD: r = a + b;
      ats_pkg::OP_CLR: r = a & ~b;
      ats_pkg::OP_EOR: r = a ^ b;
      ats_pkg::OP_SET: r = a | b;
      ats_pkg::OP_SMAX: r = ($signed(a) > $signed(b)) ? a : b;
      ats_pkg::OP_SMIN: r = ($signed(a) < $signed(b)) ? a : b;
      ats_pkg::OP_UMAX: r = (a > b) ? a : b;
      default: r = (a < b) ? a : b;
    endcase
    res_o = ats_order(r >> sh, sz, big_i);
  end
endmodule

// >>> verilog/ats_slave.sv
// Subordinate that executes atomic write-channel transactions on a local memory.
`timescale 1ns/1ps
module ats_slave #(
  parameter int DATA_W = ats_pkg::DEF_DATA_W,
  parameter int ADDR_W = ats_pkg::DEF_ADDR_W,
  parameter int ID_W = ats_pkg::DEF_ID_W,
  parameter int MEM_BYTES = ats_pkg::DEF_MEM_BYTES,
  parameter bit ATOMIC_SUPPORT = ats_pkg::DEF_ATOMIC_SUPPORT
) (
  input wire logic CLK_I,                  // Bus clock.
  input wire logic RESET_N_I,              // Asynchronous reset, active low.
  input wire logic AWVALID_I,              // Request valid.
  output logic AWREADY_O,                  // Request ready.
  input wire logic [ID_W-1:0] AWID_I,      // Request ID.
  input wire logic [ADDR_W-1:0] AWADDR_I,  // Request byte address.
  input wire logic [7:0] AWLEN_I,          // Beats minus one.
  input wire logic [2:0] AWSIZE_I,         // Log2 of beat bytes.
  input wire logic [1:0] AWBURST_I,        // Burst type.
  input wire logic AWLOCK_I,               // Lock type.
  input wire logic [3:0] AWSNOOP_I,        // Snoop field.
  input wire logic [5:0] AWATOP_I,         // Atomic operation field.
  input wire logic WVALID_I,               // Write data valid.
  output logic WREADY_O,                   // Write data ready.
  input wire logic [DATA_W-1:0] WDATA_I,   // Write data.
  input wire logic [DATA_W/8-1:0] WSTRB_I, // Write strobes.
  input wire logic WLAST_I,                // Last write beat.
  output logic BVALID_O,                   // Write response valid.
  input wire logic BREADY_I,               // Write response ready.
  output logic [ID_W-1:0] BID_O,           // Write response ID.
  output logic [1:0] BRESP_O,              // Write response code.
  output logic RVALID_O,                   // Read data valid.
  input wire logic RREADY_I,               // Read data ready.
  output logic [ID_W-1:0] RID_O,           // Read data ID.
  output logic [DATA_W-1:0] RDATA_O,       // Original memory data.
  output logic [1:0] RRESP_O,              // Read response code.
  output logic RLAST_O                     // Last read beat.
);
  localparam int DB = DATA_W / 8;
  localparam int LDB = $clog2(DB);
  localparam int MW = $clog2(MEM_BYTES);
  localparam int CB = ats_pkg::MAX_CONT_BYTES;
  localparam int OB = ats_pkg::MAX_OPND_BYTES;

  // Refuse widths the byte gathering cannot serve.
  if (DATA_W < 32 || DATA_W > 256 || (DB & (DB - 1)) != 0 || MEM_BYTES < CB ||
      (MEM_BYTES & (MEM_BYTES - 1)) != 0 || ADDR_W < MW || ID_W < 1) begin : g_bad_param
    $error("ats_slave: unsupported parameter values");
  end

  typedef struct packed {
    ats_pkg::ats_state_t st;
    logic [ID_W-1:0] id;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] base;
    logic [7:0] len;
    logic [2:0] size;
    logic [5:0] atop;
    logic err;
    logic [7:0] beat;
    logic [5:0] tot;
    logic [4:0] opsz;
    logic [CB*8-1:0] dbuf;
    logic [CB-1:0] dmask;
    logic [OB*8-1:0] old;
    logic [4:0] rbeat;
    logic [4:0] rbeats;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rlast;
  } ats_regs_t;

  ats_regs_t r;
  ats_regs_t next_r;
  logic [7:0] mem [MEM_BYTES];
  logic [CB-1:0] wen;
  logic [CB*8-1:0] wdat;
  logic [MW-1:0] widx [CB];
  logic [63:0] alu_old;
  logic [63:0] alu_arg;
  logic [63:0] alu_res;

  // Request decode and legality, from the address channel inputs.
  logic [15:0] aw_tot;
  logic [15:0] aw_opsz;
  logic aw_atomic;
  logic aw_cmp;
  logic aw_enc_ok;
  logic aw_size_ok;
  logic aw_al_op;
  logic aw_al_tot;
  logic aw_burst_ok;
  logic aw_ok;
  assign aw_tot = (16'(AWLEN_I) + 16'h1) << AWSIZE_I;
  assign aw_atomic = AWATOP_I[5:4] != ats_pkg::ATOP_KIND_NONE;
  assign aw_cmp = AWATOP_I == ats_pkg::ATOP_CMP;
  assign aw_opsz = aw_cmp ? (aw_tot >> 1) : aw_tot;
  assign aw_enc_ok = AWATOP_I[5:4] != ats_pkg::ATOP_KIND_OTHER || AWATOP_I[3:1] == 3'h0;
  assign aw_size_ok = ((aw_tot & (aw_tot - 16'h1)) == 16'h0) &&
                      (aw_cmp ? (aw_tot >= 16'h2 && aw_tot <= 16'(CB)) :
                       aw_atomic ? (aw_tot <= 16'(ats_pkg::MAX_ARITH_BYTES)) : (aw_tot <= 16'(CB)));
  assign aw_al_op = (AWADDR_I & (ADDR_W'(aw_opsz) - ADDR_W'(1))) == '0;
  assign aw_al_tot = (AWADDR_I & (ADDR_W'(aw_tot) - ADDR_W'(1))) == '0;
  // Aligned requests take INCR; unaligned compare takes WRAP; single-beat atomic WRAP is accepted.
  assign aw_burst_ok = (AWBURST_I == ats_pkg::BURST_INCR && aw_al_tot) ||
                       (AWBURST_I == ats_pkg::BURST_WRAP && aw_cmp && !aw_al_tot) ||
                       (AWBURST_I == ats_pkg::BURST_WRAP && aw_atomic && AWLEN_I == 8'h0);
  assign aw_ok = aw_enc_ok && aw_size_ok && aw_al_op && aw_burst_ok &&
                 (AWLEN_I == 8'h0 || AWSIZE_I == 3'(LDB)) &&
                 !AWLOCK_I && AWSNOOP_I == 4'h0 &&
                 (!aw_atomic || ATOMIC_SUPPORT);

  // Places the prior operand bytes into the lanes of one read beat.
  function automatic logic [DATA_W-1:0] ats_rd_beat(input logic [ADDR_W-1:0] a, input logic [4:0] sz,
                                                    input logic [4:0] rb, input logic [OB*8-1:0] ov);
    logic [ADDR_W-1:0] k;
    logic [DATA_W-1:0] d;
    d = '0;
    for (int j = 0; j < DB; j++) begin
      k = ((a & ~ADDR_W'(DB - 1)) + ADDR_W'(rb) * ADDR_W'(DB) + ADDR_W'(j)) - a;
      if (k < ADDR_W'(sz)) begin
        d[j*8 +: 8] = ov[k[3:0]*8 +: 8];
      end
    end
    return d;
  endfunction

  ats_alu u_alu (
    .old_i(alu_old),
    .arg_i(alu_arg),
    .op_i(r.atop[2:0]),
    .size_i(r.opsz),
    .big_i(r.atop[ats_pkg::ATOP_BIG_BIT]),
    .res_o(alu_res)
  );

  // Next-state logic; one transaction at a time, so a later access never sees a half-done update.
  always_comb begin
    logic [ADDR_W-1:0] bb;
    logic [ADDR_W-1:0] boff;
    logic [ADDR_W-1:0] lane0;
    logic [ADDR_W-1:0] idx;
    logic [ADDR_W-1:0] opa;
    logic [4:0] aoff;
    logic [4:0] soff;
    logic [OB*8-1:0] oldv;
    logic [OB*8-1:0] argv;
    logic [OB*8-1:0] swpv;
    logic [OB*8-1:0] opmask;
    logic [OB*8-1:0] newv;
    logic has_rd;
    next_r = r;
    newv = '0;
    wen = '0;
    wdat = '0;
    bb = ADDR_W'(1) << r.size;
    boff = (((r.addr & ~(bb - ADDR_W'(1))) - r.base) + ADDR_W'(r.beat) * bb) & (ADDR_W'(r.tot) - ADDR_W'(1));
    lane0 = (r.base + boff) & ~ADDR_W'(DB - 1);
    idx = '0;
    opa = r.addr & ~(ADDR_W'(r.opsz) - ADDR_W'(1));
    aoff = 5'(opa - r.base);
    soff = aoff ^ r.opsz;
    oldv = '0;
    argv = '0;
    swpv = '0;
    opmask = '0;
    for (int i = 0; i < OB; i++) begin
      if (5'(i) < r.opsz) begin
        oldv[i*8 +: 8] = mem[MW'(opa + ADDR_W'(i))];
        argv[i*8 +: 8] = r.dbuf[5'(aoff + 5'(i))*8 +: 8];
        swpv[i*8 +: 8] = r.dbuf[5'(soff + 5'(i))*8 +: 8];
        opmask[i*8 +: 8] = 8'hff;
      end
    end
    alu_old = oldv[63:0];
    alu_arg = argv[63:0];
    has_rd = r.atop[5:4] == ats_pkg::ATOP_KIND_LOAD || r.atop[5:4] == ats_pkg::ATOP_KIND_OTHER;
    for (int i = 0; i < CB; i++) begin
      widx[i] = MW'((r.atop[5:4] == ats_pkg::ATOP_KIND_NONE ? r.base : opa) + ADDR_W'(i));
    end
    case (r.st)
      ats_pkg::ST_IDLE: begin
        next_r.awready = 1'b1;
        if (AWVALID_I && r.awready) begin
          next_r.awready = 1'b0;
          next_r.wready = 1'b1;
          next_r.st = ats_pkg::ST_DATA;
          next_r.id = AWID_I;
          next_r.addr = AWADDR_I;
          next_r.base = AWADDR_I & ~(ADDR_W'(aw_tot) - ADDR_W'(1));
          next_r.len = AWLEN_I;
          next_r.size = AWSIZE_I;
          next_r.atop = AWATOP_I;
          next_r.err = !aw_ok;
          next_r.beat = 8'h0;
          next_r.tot = aw_tot[5:0];
          next_r.opsz = aw_opsz[4:0];
          next_r.dbuf = '0;
          next_r.dmask = '0;
        end
      end
      ats_pkg::ST_DATA: begin
        if (WVALID_I && r.wready) begin
          // Bytes land at their offset inside the container, so WRAP order needs no special case.
          for (int j = 0; j < DB; j++) begin
            idx = lane0 + ADDR_W'(j) - r.base;
            if (WSTRB_I[j] && idx < ADDR_W'(r.tot)) begin
              next_r.dbuf[idx[4:0]*8 +: 8] = WDATA_I[j*8 +: 8];
              next_r.dmask[idx[4:0]] = 1'b1;
            end
          end
          next_r.beat = r.beat + 8'h1;
          if (WLAST_I != (r.beat == r.len)) begin
            next_r.err = 1'b1;
          end
          if (r.beat == r.len) begin
            next_r.wready = 1'b0;
            next_r.st = ats_pkg::ST_EXEC;
          end
        end
      end
      ats_pkg::ST_EXEC: begin
        // Read, operate and write back in this one cycle.
        case (r.atop[5:4])
          ats_pkg::ATOP_KIND_OTHER: newv = (r.atop == ats_pkg::ATOP_CMP) ?
                                           ((((oldv ^ argv) & opmask) == '0) ? swpv : oldv) :
                                           argv;
          default: newv = {{(OB*8-64){1'b0}}, alu_res};
        endcase
        if (!r.err) begin
          if (r.atop[5:4] == ats_pkg::ATOP_KIND_NONE) begin
            wen = r.dmask;
            wdat = r.dbuf;
          end else begin
            for (int i = 0; i < OB; i++) begin
              wen[i] = 5'(i) < r.opsz;
            end
            wdat[OB*8-1:0] = newv;
          end
        end
        next_r.old = r.err ? '0 : oldv;
        next_r.st = ats_pkg::ST_RESP;
        next_r.bvalid = 1'b1;
        next_r.bresp = r.err ? ats_pkg::RESP_SLVERR : ats_pkg::RESP_OKAY;
        next_r.rbeat = 5'h0;
        next_r.rbeats = 5'((32'(r.opsz) - 1) >> LDB) + 5'h1;
        if (has_rd) begin
          next_r.rvalid = 1'b1;
          next_r.rdata = ats_rd_beat(opa, r.opsz, 5'h0, r.err ? '0 : oldv);
          next_r.rresp = next_r.bresp;
          next_r.rlast = next_r.rbeats == 5'h1;
        end
      end
      default: begin
        if (r.bvalid && BREADY_I) begin
          next_r.bvalid = 1'b0;
        end
        if (r.rvalid && RREADY_I) begin
          if (r.rlast) begin
            next_r.rvalid = 1'b0;
            next_r.rlast = 1'b0;
          end else begin
            next_r.rbeat = r.rbeat + 5'h1;
            next_r.rdata = ats_rd_beat(opa, r.opsz, r.rbeat + 5'h1, r.old);
            next_r.rlast = (r.rbeat + 5'h2) == r.rbeats;
          end
        end
        if (!next_r.bvalid && !next_r.rvalid) begin
          next_r.st = ats_pkg::ST_IDLE;
          next_r.awready = 1'b1;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r <= {$bits(ats_regs_t){ats_pkg::RESET_VALUE}};
    end else begin
      r <= next_r;
    end
  end

  // Memory has no reset; its contents are undefined until written.
  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < CB; i++) begin
      if (wen[i]) begin
        mem[widx[i]] <= wdat[i*8 +: 8];
      end
    end
  end

  // Outputs come straight from the state register.
  assign AWREADY_O = r.awready;
  assign WREADY_O = r.wready;
  assign BVALID_O = r.bvalid;
  assign BID_O = r.id;
  assign BRESP_O = r.bresp;
  assign RVALID_O = r.rvalid;
  assign RID_O = r.id;
  assign RDATA_O = r.rdata;
  assign RRESP_O = r.rresp;
  assign RLAST_O = r.rlast;
endmodule

// >>> verification/ats_props.sv
// Checker of handshake timing and ID echo at the atomic slave ports.
`timescale 1ns/1ps
module ats_props #(
  parameter int ID_W = 4
) (
  input wire logic CLK_I,            // Clock.
  input wire logic RESET_N_I,        // Reset, active low.
  input wire logic AWVALID_I,        // Request valid.
  input wire logic AWREADY_O,        // Request ready.
  input wire logic [ID_W-1:0] AWID_I, // Request ID.
  input wire logic AWLOCK_I,         // Lock type.
  input wire logic [5:0] AWATOP_I,   // Operation.
  input wire logic WVALID_I,         // Data valid.
  input wire logic WREADY_O,         // Data ready.
  input wire logic WLAST_I,          // Last beat.
  input wire logic BVALID_O,         // Response valid.
  input wire logic BREADY_I,         // Response ready.
  input wire logic [ID_W-1:0] BID_O, // Response ID.
  input wire logic [1:0] BRESP_O,    // Response code.
  input wire logic RVALID_O,         // Read valid.
  input wire logic RREADY_I,         // Read ready.
  input wire logic [ID_W-1:0] RID_O, // Read ID.
  input wire logic [1:0] RRESP_O     // Read code.
);
  logic [ID_W-1:0] id_q;
  logic rd_q;
  logic lk_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Keep what the taken request asked for, since the answers come much later.
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      id_q <= '0;
      rd_q <= 1'b0;
      lk_q <= 1'b0;
    end else if (AWVALID_I && AWREADY_O) begin
      id_q <= AWID_I;
      rd_q <= AWATOP_I[5];
      lk_q <= AWLOCK_I;
    end
  end
  a_resp_after_w: assert property (WVALID_I && WREADY_O && WLAST_I |->
    ##1 !BVALID_O ##1 (BVALID_O && RVALID_O == rd_q))
    else $error("write response not two cycles after last beat");
  a_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BID_O) && $stable(BRESP_O))
    else $error("write response changed before it was taken");
  a_r_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RID_O) && $stable(RRESP_O))
    else $error("read beat changed before it was taken");
  a_b_once: assert property (BVALID_O && BREADY_I |=> !BVALID_O [*3])
    else $error("second write response");
  a_bid_echo: assert property (BVALID_O |-> BID_O == id_q)
    else $error("write response ID differs from request");
  a_rid_echo: assert property (RVALID_O |-> RID_O == id_q)
    else $error("read ID differs from request");
  a_store_no_r: assert property (RVALID_O |-> rd_q)
    else $error("read data for a store");
  a_one_txn: assert property (BVALID_O || RVALID_O |-> !AWREADY_O)
    else $error("request accepted while one is in progress");
  a_w_open: assert property (AWVALID_I && AWREADY_O |=> WREADY_O && !AWREADY_O)
    else $error("write channel not opened after request");
  a_lock_err: assert property (BVALID_O && lk_q |-> BRESP_O == ats_pkg::RESP_SLVERR)
    else $error("locked atomic not refused");
endmodule
bind ats_slave ats_props #(.ID_W(ID_W)) u_props (.CLK_I, .RESET_N_I, .AWVALID_I, .AWREADY_O, .AWID_I, .AWLOCK_I,
  .AWATOP_I, .WVALID_I, .WREADY_O, .WLAST_I, .BVALID_O, .BREADY_I, .BID_O, .BRESP_O, .RVALID_O, .RREADY_I,
  .RID_O, .RRESP_O);

// >>> verification/ats_mgr.sv
// Bus manager model that issues one single-beat atomic request at a time.
`timescale 1ns/1ps
module ats_mgr (
  input wire logic clk_i,        // Clock.
  output logic awvalid_o,        // Request valid.
  input wire logic awready_i,    // Request ready.
  output logic [3:0] awid_o,     // Request ID.
  output logic [31:0] awaddr_o,  // Address.
  output logic [2:0] awsize_o,   // Beat size.
  output logic [1:0] awburst_o,  // Burst type.
  output logic awlock_o,         // Lock type.
  output logic [5:0] awatop_o,   // Operation.
  output logic wvalid_o,         // Data valid.
  input wire logic wready_i,     // Data ready.
  output logic [63:0] wdata_o,   // Data.
  output logic [7:0] wstrb_o,    // Strobes.
  output logic wlast_o,          // Last beat.
  input wire logic bvalid_i,     // Response valid.
  output logic bready_o,         // Response ready.
  input wire logic [3:0] bid_i,  // Response ID.
  input wire logic [1:0] bresp_i, // Response code.
  input wire logic rvalid_i,     // Read valid.
  output logic rready_o,         // Read ready.
  input wire logic [3:0] rid_i,  // Read ID.
  input wire logic [63:0] rdata_i, // Read data.
  input wire logic [1:0] rresp_i, // Read code.
  input wire logic rlast_i       // Read last.
);
  int stall;
  logic [3:0] bid, rid;
  logic [1:0] bresp, rresp;
  logic [63:0] rdata;
  logic rl;
  // Idle levels from time zero; stall sets how long the far side lags.
  initial begin
    {awvalid_o, wvalid_o, bready_o, rready_o, awlock_o, wlast_o} = '0;
    {awid_o, awaddr_o, awsize_o, awburst_o, awatop_o, wdata_o, wstrb_o} = '0;
    stall = 0;
  end
  // Caller keeps sizes, alignment, bursts, strobes and IDs legal.
  // The same holds for unaligned compare bursts; IDs may repeat.
  task automatic xfer(input logic [3:0] id, input logic [31:0] a, input logic [2:0] sz, input logic [1:0] bu,
                      input logic lk, input logic [5:0] op, input logic [63:0] d, input logic [7:0] s,
                      input bit need_r, output bit ok);
    int n;
    int wc;
    bit aw_d, w_d, b_d, r_d;
    n = 0;
    wc = 0;
    aw_d = 0;
    w_d = 0;
    b_d = 0;
    r_d = !need_r;
    @(posedge clk_i);
    awvalid_o <= 1'b1;
    awid_o <= id;
    awaddr_o <= a;
    awsize_o <= sz;
    awburst_o <= bu;
    awlock_o <= lk;
    awatop_o <= op;
    wvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= s;
    wlast_o <= 1'b1;
    // Address and data released by the manager are inverted so stale data never looks valid.
    while (!(aw_d && w_d && b_d && r_d) && n < 80) begin
      @(posedge clk_i);
      n++;
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
        aw_d = 1;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
        w_d = 1;
      end
      if (bvalid_i || rvalid_i) wc++;
      if (bvalid_i && bready_o) begin
        bid = bid_i;
        bresp = bresp_i;
        bready_o <= 1'b0;
        b_d = 1;
      end else if (bvalid_i && wc > stall) bready_o <= 1'b1;
      if (rvalid_i && rready_o) begin
        rid = rid_i;
        rresp = rresp_i;
        rdata = rdata_i;
        rl = rlast_i;
        rready_o <= 1'b0;
        r_d = 1;
      end else if (rvalid_i && wc > stall) rready_o <= 1'b1;
    end
    ok = aw_d && w_d && b_d && r_d;
  endtask
endmodule

// >>> verification/test_atomic_txn_slave.sv
// Self-checking testbench of the atomic slave with operator, compare and refusal cases.
`timescale 1ns/1ps
`define ATS_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_atomic_txn_slave;
  logic CLK_I = 1'b0;
  logic RESET_N_I = 1'b0;
  logic AWVALID_I, AWREADY_O, AWLOCK_I, WVALID_I, WREADY_O, WLAST_I, BVALID_O, BREADY_I, RVALID_O, RREADY_I, RLAST_O;
  logic [3:0] AWID_I, BID_O, RID_O;
  logic [3:0] AWSNOOP_I = 4'h0;
  logic [31:0] AWADDR_I;
  logic [2:0] AWSIZE_I;
  logic [1:0] AWBURST_I, BRESP_O, RRESP_O;
  logic [5:0] AWATOP_I;
  logic [63:0] WDATA_I, RDATA_O;
  logic [7:0] WSTRB_I;
  int mismatches = 0;
  int checked = 0;
  localparam logic [5:0] SWP = ats_pkg::ATOP_SWAP;
  localparam logic [1:0] INC = ats_pkg::BURST_INCR;
  ats_slave u_dut (.CLK_I, .RESET_N_I, .AWVALID_I, .AWREADY_O, .AWID_I, .AWADDR_I, .AWLEN_I(8'h00), .AWSIZE_I,
    .AWBURST_I, .AWLOCK_I, .AWSNOOP_I, .AWATOP_I, .WVALID_I, .WREADY_O, .WDATA_I, .WSTRB_I, .WLAST_I,
    .BVALID_O, .BREADY_I, .BID_O, .BRESP_O, .RVALID_O, .RREADY_I, .RID_O, .RDATA_O, .RRESP_O, .RLAST_O);
  ats_mgr u_mgr (.clk_i(CLK_I), .awvalid_o(AWVALID_I), .awready_i(AWREADY_O), .awid_o(AWID_I), .awaddr_o(AWADDR_I),
    .awsize_o(AWSIZE_I), .awburst_o(AWBURST_I), .awlock_o(AWLOCK_I), .awatop_o(AWATOP_I), .wvalid_o(WVALID_I),
    .wready_i(WREADY_O), .wdata_o(WDATA_I), .wstrb_o(WSTRB_I), .wlast_o(WLAST_I), .bvalid_i(BVALID_O),
    .bready_o(BREADY_I), .bid_i(BID_O), .bresp_i(BRESP_O), .rvalid_i(RVALID_O), .rready_o(RREADY_I),
    .rid_i(RID_O), .rdata_i(RDATA_O), .rresp_i(RRESP_O), .rlast_i(RLAST_O));
  // Free-running 125 MHz clock.
  always #4 CLK_I = ~CLK_I;
  // Prints the counts and the verdict; every path of the run ends here.
  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One transfer; a hung transfer ends the run.
  task automatic run(input logic [3:0] id, input logic [31:0] a, input logic [2:0] sz, input logic [1:0] bu,
                     input logic lk, input logic [5:0] op, input logic [63:0] d, input logic [7:0] s, input bit nr);
    bit ok;
    u_mgr.xfer(id, a, sz, bu, lk, op, d, s, nr, ok);
    if (!ok) begin
      mismatches++;
      $display("mismatch at %0t: transfer did not complete", $time);
      end_sim();
    end
  endtask
  // Reference result of a four-byte operator, big-endian handled by byte reversal.
  function automatic logic [31:0] exp_op(input int op, input bit big, input logic [31:0] m, input logic [31:0] d);
    logic [31:0] mm, dd, r;
    mm = big ? {<<8{m}} : m;
    dd = big ? {<<8{d}} : d;
    case (op)
      0: r = mm + dd;
      1: r = mm & ~dd;
      2: r = mm ^ dd;
      3: r = mm | dd;
      4: r = ($signed(mm) > $signed(dd)) ? mm : dd;
      5: r = ($signed(mm) < $signed(dd)) ? mm : dd;
      6: r = (mm > dd) ? mm : dd;
      default: r = (mm < dd) ? mm : dd;
    endcase
    return big ? {<<8{r}} : r;
  endfunction
  // Two swaps back to back: the second returns what the first stored.
  task automatic t_swap();
    run(4'h1, 32'h0, 3'h3, INC, 1'b0, SWP, 64'h1122334455667788, 8'hff, 1);
    run(4'h2, 32'h0, 3'h3, INC, 1'b0, SWP, 64'hcafef00d0badbeef, 8'hff, 1);
    `ATS_CHK(u_mgr.rdata, 64'h1122334455667788)
    `ATS_CHK({u_mgr.rid, u_mgr.bid, u_mgr.bresp, u_mgr.rl}, {4'h2, 4'h2, ats_pkg::RESP_OKAY, 1'b1})
  endtask
  // Every operator, loads and stores alternating, then endianness on an arithmetic and a bitwise operator.
  task automatic t_ops();
    logic [31:0] m, d;
    logic [5:0] op;
    m = 32'h80007ff0;
    d = 32'h00008011;
    for (int i = 0; i < 10; i++) begin
      op = {(i % 2) ? ats_pkg::ATOP_KIND_STORE : ats_pkg::ATOP_KIND_LOAD, i >= 8, 3'(i % 8)};
      run(4'h3, 32'h8, 3'h2, INC, 1'b0, SWP, {32'h0, m}, 8'h0f, 1);
      run(4'h4, 32'h8, 3'h2, INC, 1'b0, op, {32'h0, d}, 8'h0f, i % 2 == 0);
      if (i % 2 == 0) `ATS_CHK(u_mgr.rdata[31:0], m)
      run(4'h5, 32'h8, 3'h2, INC, 1'b0, SWP, 64'h0, 8'h0f, 1);
      `ATS_CHK(u_mgr.rdata[31:0], exp_op(i % 8, i >= 8, m, d))
    end
  endtask
  // Compare hit and miss, then a swap-first single-beat wrap compare, with a slow far side.
  task automatic t_cmp();
    u_mgr.stall = 3;
    run(4'h6, 32'h10, 3'h2, INC, 1'b0, SWP, 64'h0000000012345678, 8'h0f, 1);
    run(4'h7, 32'h10, 3'h3, INC, 1'b0, ats_pkg::ATOP_CMP, 64'haaaa555512345678, 8'hff, 1);
    `ATS_CHK({u_mgr.rdata[31:0], u_mgr.rl}, {32'h12345678, 1'b1})
    run(4'h8, 32'h10, 3'h3, INC, 1'b0, ats_pkg::ATOP_CMP, 64'h9999999912345678, 8'hff, 1);
    `ATS_CHK(u_mgr.rdata[31:0], 32'haaaa5555)
    run(4'h9, 32'h10, 3'h2, INC, 1'b0, SWP, 64'h0, 8'h0f, 1);
    `ATS_CHK(u_mgr.rdata[31:0], 32'haaaa5555)
    run(4'ha, 32'h14, 3'h2, INC, 1'b0, SWP, 64'h7654321000000000, 8'hf0, 1);
    run(4'hb, 32'h14, 3'h3, ats_pkg::BURST_WRAP, 1'b0, ats_pkg::ATOP_CMP, 64'h765432100f0f0f0f, 8'hff, 1);
    `ATS_CHK({u_mgr.rdata[63:32], u_mgr.bresp}, {32'h76543210, ats_pkg::RESP_OKAY})
    run(4'hc, 32'h14, 3'h2, INC, 1'b0, SWP, 64'h0, 8'hf0, 1);
    `ATS_CHK(u_mgr.rdata[63:32], 32'h0f0f0f0f)
    u_mgr.stall = 0;
  endtask
  // Misaligned, locked and snooping requests are refused; each would change the word at 8 if it ran.
  task automatic t_err();
    run(4'hd, 32'ha, 3'h2, INC, 1'b0, {ats_pkg::ATOP_KIND_LOAD, 4'h0}, 64'h0000000000010000, 8'h3c, 1);
    `ATS_CHK({u_mgr.bresp, u_mgr.rresp}, {ats_pkg::RESP_SLVERR, ats_pkg::RESP_SLVERR})
    `ATS_CHK(u_mgr.rdata, 64'h0)
    run(4'he, 32'h8, 3'h2, INC, 1'b1, SWP, 64'h5, 8'h0f, 1);
    `ATS_CHK(u_mgr.bresp, ats_pkg::RESP_SLVERR)
    AWSNOOP_I <= 4'h1;
    run(4'h1, 32'h8, 3'h2, INC, 1'b0, SWP, 64'h7, 8'h0f, 1);
    AWSNOOP_I <= 4'h0;
    `ATS_CHK(u_mgr.bresp, ats_pkg::RESP_SLVERR)
    run(4'hf, 32'h8, 3'h3, INC, 1'b0, SWP, 64'h0, 8'hff, 1);
    `ATS_CHK(u_mgr.rdata[31:0], 32'h0)
  endtask
  // Reset for two cycles, then the scenarios in turn.
  initial begin
    repeat (2) @(posedge CLK_I);
    RESET_N_I <= 1'b1;
    t_swap();
    t_ops();
    t_cmp();
    t_err();
    end_sim();
  end
endmodule
